// file: common/efla_pkg.sv
// Constants shared by the edge flop and latch array
package efla_pkg;
    // Element kinds
    localparam int KIND_JK_EDGE_FLOP = 0; // Falling edge JK
    localparam int KIND_DATA_EDGE_FLOP = 1; // Rising edge D
    localparam int KIND_SR_GATED_LATCH = 2; // Set reset gated latch
    localparam int KIND_DATA_GATED_LATCH = 3; // Data gated latch
    // Power on state selection codes
    localparam int INIT_SEL_ZERO = 0; // Start at 0
    localparam int INIT_SEL_ONE = 1; // Start at 1
    // Timing
    localparam int SYS_CLK_PERIOD_NS = 40; // 25 MHz
    localparam int CLK_TO_Q_NS = 40; // Default edge to output delay
    localparam int SETUP_NS = 0; // Default setup check, zero is off
    // Counter width for delay and setup counting
    localparam int CNT_W = 8;
endpackage : efla_pkg

// file: rtl/efla_array.sv
// Parameterised array of edge flops and gated latches
`timescale 1ns/10ps
// Operation
// [R1] JK flop updates only on falling clock
// [R2] D flop updates only on rising clock
// [R3] State changes a set delay after edge
// [R4] Count parameter; shared set, clear, clock
// [R5] Schematic instance forced to single element
// [R6] Clear forces 0, set forces 1
// [R7] JK: hold, clear, set, toggle on edge
// [R8] D flop copies data on rising edge
// [R9] Latch follows while gate high, holds low
// [R10] Power on selection: 0, 1, else unknown
// [R11] Unknown input harmless when resolutions agree
// [R12] Unknown input disagreeing makes output unknown
// [R13] Nonzero timing check warns, keeps state
// [R14] Complement inverse except both async low
// [R15] Registered outputs, async controls active low
module efla_array #(
    parameter int KIND = efla_pkg::KIND_DATA_EDGE_FLOP,
    parameter int COUNT = 1, // Elements sharing set, clear and clock [R4]
    parameter bit TEXT_FORM = 1'b1,
    parameter int POWER_ON_STATE_SELECT = 2,
    parameter int CLK_TO_Q_NS = efla_pkg::CLK_TO_Q_NS,
    parameter int SETUP_NS = efla_pkg::SETUP_NS
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Shared element controls
    input wire logic elem_clk,
    input wire logic preset_n,
    input wire logic clear_n,
    input wire logic preset_unknown,
    input wire logic clear_unknown,
    // Per element data: j, d or s on a; k or r on b
    input wire logic [COUNT-1:0] data_a,
    input wire logic [COUNT-1:0] data_b,
    // Outputs
    output logic [COUNT-1:0] true_output,
    output logic [COUNT-1:0] complement_output,
    output logic [COUNT-1:0] unknown_output,
    output logic timing_warn
);
    ////////////////////////////////////////////////////////////////////
    // Derived constants
    localparam int ACTIVE = TEXT_FORM ? COUNT : 1; // Elements in use [R5]
    localparam int DLY_RAW = CLK_TO_Q_NS / efla_pkg::SYS_CLK_PERIOD_NS;
    localparam int DLY_CYC = (DLY_RAW < 1) ? 1 : DLY_RAW; // Longest time rounds down
    localparam int SU_CYC = (SETUP_NS + efla_pkg::SYS_CLK_PERIOD_NS - 1) / efla_pkg::SYS_CLK_PERIOD_NS;
    localparam bit IS_LATCH = (KIND >= efla_pkg::KIND_SR_GATED_LATCH);
    localparam bit INIT_Q = (POWER_ON_STATE_SELECT == efla_pkg::INIT_SEL_ONE);
    localparam bit INIT_X = (POWER_ON_STATE_SELECT != efla_pkg::INIT_SEL_ZERO) && !INIT_Q;
    localparam logic [efla_pkg::CNT_W-1:0] DLY_LOAD = efla_pkg::CNT_W'(DLY_CYC);
    localparam logic [efla_pkg::CNT_W-1:0] SU_LIM = efla_pkg::CNT_W'(SU_CYC);
    localparam logic [efla_pkg::CNT_W-1:0] CNT_ONE = efla_pkg::CNT_W'(1);

    ////////////////////////////////////////////////////////////////////
    // Shared edge detection and delay timing
    logic clk_prev_reg; // Element clock one cycle ago
    logic [efla_pkg::CNT_W-1:0] dly_cnt_reg; // Cycles to commit
    logic [efla_pkg::CNT_W-1:0] stable_cnt_reg; // Cycles data stable
    logic [COUNT-1:0] a_prev_reg; // Data history for setup check
    logic [COUNT-1:0] b_prev_reg;
    logic act_edge; // Active event this cycle
    logic commit; // Pending value lands now
    logic data_moved; // Data differs from the last cycle
    logic [efla_pkg::CNT_W-1:0] stable_now; // Cycles data has stood, this edge included

    // Active event per kind
    always_comb begin
        case (KIND)
            efla_pkg::KIND_JK_EDGE_FLOP: act_edge = clk_prev_reg & ~elem_clk; // [R1]
            efla_pkg::KIND_DATA_EDGE_FLOP: act_edge = ~clk_prev_reg & elem_clk; // [R2]
            default: act_edge = elem_clk; // Latch transparent while gate high [R9]
        endcase
        // Clock events under an async force are ignored, so no stale capture lands later
        if (!preset_n || !clear_n) begin
            act_edge = 1'b0; // [R6]
        end
    end

    assign commit = (dly_cnt_reg == CNT_ONE);

    // Clock history
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_prev_reg <= 1'b0;
        end else begin
            clk_prev_reg <= elem_clk;
        end
    end

    // Delay countdown, restarted by every active event
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dly_cnt_reg <= '0;
        end else if (act_edge) begin
            dly_cnt_reg <= DLY_LOAD; // [R3]
        end else if (dly_cnt_reg != '0) begin
            dly_cnt_reg <= dly_cnt_reg - CNT_ONE;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Stability count including the data seen at this edge
    assign data_moved = (data_a != a_prev_reg) || (data_b != b_prev_reg);
    always_comb begin
        if (data_moved) begin
            stable_now = '0; // Changed together with the clock
        end else if (stable_cnt_reg == '1) begin
            stable_now = stable_cnt_reg; // Saturated
        end else begin
            stable_now = stable_cnt_reg + CNT_ONE;
        end
    end

    // Setup check, only when configured nonzero
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            a_prev_reg <= '0;
            b_prev_reg <= '0;
            stable_cnt_reg <= '0;
            timing_warn <= 1'b0;
        end else begin
            a_prev_reg <= data_a;
            b_prev_reg <= data_b;
            stable_cnt_reg <= stable_now;
            // Warning only; state path never reads it [R13]
            timing_warn <= (SU_CYC != 0) && !IS_LATCH && act_edge && (stable_now < SU_LIM);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Async override result for one resolution of preset and clear
    function automatic logic [1:0] async_res(input logic p_n, input logic c_n, input logic h);
        logic [1:0] r;
        r = {h, ~h}; // Both inactive: hold value
        if (!p_n && !c_n) begin
            r = 2'b11; // Unstable, both outputs high
        end else if (!p_n) begin
            r = 2'b10;
        end else if (!c_n) begin
            r = 2'b01;
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Per element storage
    genvar gi;
    generate
        for (gi = 0; gi < COUNT; gi++) begin : g_elem
            logic pend_reg; // Value waiting for delay
            logic nxt; // Synchronous next value
            logic hold_q; // Value with commit applied
            logic [1:0] res_ref; // First resolution
            logic res_unk; // Resolutions disagree
            logic p_alt; // Alternate preset resolution
            logic c_alt; // Alternate clear resolution
            logic h_alt; // Alternate hold resolution

            // Function of the kind on the shared event
            always_comb begin
                case (KIND)
                    efla_pkg::KIND_JK_EDGE_FLOP: begin
                        case ({data_a[gi], data_b[gi]})
                            2'b01: nxt = 1'b0; // [R7]
                            2'b10: nxt = 1'b1; // [R7]
                            2'b11: nxt = ~hold_q; // [R7]
                            default: nxt = hold_q; // [R7]
                        endcase
                    end
                    efla_pkg::KIND_SR_GATED_LATCH: begin
                        case ({data_a[gi], data_b[gi]})
                            2'b01: nxt = 1'b0;
                            2'b10: nxt = 1'b1;
                            default: nxt = hold_q; // Both high held, value after any commit
                        endcase
                    end
                    default: nxt = data_a[gi]; // [R8] [R9]
                endcase
            end

            // Capture on the active event
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    pend_reg <= INIT_Q;
                end else if (act_edge) begin
                    pend_reg <= nxt; // [R3]
                end
            end

            // Pessimistic resolution over unknown preset, clear and state
            always_comb begin
                hold_q = commit ? pend_reg : true_output[gi];
                res_ref = async_res(preset_n, clear_n, hold_q);
                res_unk = 1'b0;
                p_alt = ~preset_n;
                c_alt = ~clear_n;
                h_alt = ~hold_q;
                if (preset_unknown && async_res(p_alt, clear_n, hold_q) != res_ref) begin
                    res_unk = 1'b1; // [R12]
                end
                if (clear_unknown && async_res(preset_n, c_alt, hold_q) != res_ref) begin
                    res_unk = 1'b1; // [R12]
                end
                if (preset_unknown && clear_unknown && async_res(p_alt, c_alt, hold_q) != res_ref) begin
                    res_unk = 1'b1;
                end
                if (unknown_output[gi] && !commit && async_res(preset_n, clear_n, h_alt) != res_ref) begin
                    res_unk = 1'b1; // Unknown state persists until a commit lands or an async force
                end
            end

            // Output registers
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    true_output[gi] <= INIT_Q; // [R10] [R15]
                    complement_output[gi] <= ~INIT_Q; // [R10]
                    unknown_output[gi] <= INIT_X; // [R10]
                end else if (gi >= ACTIVE) begin
                    true_output[gi] <= 1'b0; // [R5]
                    complement_output[gi] <= 1'b1;
                    unknown_output[gi] <= 1'b0;
                end else begin
                    true_output[gi] <= res_ref[1]; // [R6] [R11]
                    complement_output[gi] <= res_ref[0]; // [R14]
                    unknown_output[gi] <= res_unk; // [R11] [R12]
                end
            end

            // True output moves only on a commit or an async force
            quiet_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
                (preset_n && clear_n && !preset_unknown && !clear_unknown && !commit && gi < ACTIVE)
                |=> $stable(true_output[gi])) else $error("Output moved without event"); // [R3]
            clear_force_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
                (preset_n && !clear_n && !preset_unknown && !clear_unknown && gi < ACTIVE)
                |=> (true_output[gi] == 1'b0 && complement_output[gi] == 1'b1)) else $error("Clear not forced"); // [R6]
            preset_force_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
                (!preset_n && clear_n && !preset_unknown && !clear_unknown && gi < ACTIVE)
                |=> (true_output[gi] && !complement_output[gi])) else $error("Preset not forced"); // [R6]
            compl_inverse_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
                $past(preset_n | clear_n) |-> (complement_output[gi] == ~true_output[gi]))
                else $error("Complement not inverse"); // [R14]
            unknown_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
                (clear_unknown && !preset_unknown && preset_n && !commit && !unknown_output[gi]
                 && true_output[gi] && gi < ACTIVE) |=> unknown_output[gi]) else $error("Unknown not raised"); // [R12]
            known_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
                (clear_unknown && !preset_unknown && preset_n && !commit && !unknown_output[gi]
                 && !true_output[gi] && gi < ACTIVE) |=> (!unknown_output[gi] && !true_output[gi]))
                else $error("Unknown spread needlessly"); // [R11]
            if (KIND == efla_pkg::KIND_JK_EDGE_FLOP) begin : g_jk_chk
                jk_toggle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
                    (act_edge && data_a[gi] && data_b[gi] && DLY_CYC == 1 && gi < ACTIVE)
                    ##1 (preset_n && clear_n && !preset_unknown && !clear_unknown)
                    |=> (true_output[gi] == ~$past(true_output[gi], 2))) else $error("JK toggle wrong"); // [R7]
            end
            if (KIND == efla_pkg::KIND_DATA_EDGE_FLOP) begin : g_d_chk
                d_copy_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
                    (act_edge && DLY_CYC == 1 && gi < ACTIVE)
                    ##1 (preset_n && clear_n && !preset_unknown && !clear_unknown)
                    |=> (true_output[gi] == $past(data_a[gi], 2))) else $error("D copy wrong"); // [R8]
            end
        end
    endgenerate

    // Rising edge only for the D flop, never on the falling edge
    d_edge_only_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (KIND == efla_pkg::KIND_DATA_EDGE_FLOP && clk_prev_reg && !elem_clk && dly_cnt_reg == '0)
        |=> (dly_cnt_reg == '0)) else $error("D flop took falling edge"); // [R2]
    jk_edge_only_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (KIND == efla_pkg::KIND_JK_EDGE_FLOP && !clk_prev_reg && elem_clk && dly_cnt_reg == '0)
        |=> (dly_cnt_reg == '0)) else $error("JK flop took rising edge"); // [R1]
    delay_count_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        act_edge ##1 !act_edge |-> (dly_cnt_reg == DLY_LOAD)) else $error("Delay not loaded"); // [R3]
    setup_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (SU_CYC == 0) |-> !timing_warn) else $error("Warning with check off"); // [R13]
endmodule : efla_array

// file: testbench/efla_drv.sv
// Model of the surrounding logic that drives the element clock and async controls
`timescale 1ns/10ps
module efla_drv (
    // Clock
    input wire logic sys_clk,
    // Requests from the bench
    input wire logic run,
    input wire logic pre_req,
    input wire logic clr_req,
    // Driven element controls
    output logic elem_clk,
    output logic preset_n,
    output logic clear_n
);
    ////////////////////////////////////////////////////////////
    logic run_s; // Run request as sampled at the edge
    initial elem_clk = 1'b0;
    // Element clock toggles each cycle while running, stands still otherwise
    always @(posedge sys_clk) begin
        run_s = run;
        #1 elem_clk = run_s ? ~elem_clk : elem_clk;
    end
    // Never both async controls low at once; clear wins over preset
    assign clear_n = ~clr_req;
    assign preset_n = ~(pre_req & ~clr_req);
endmodule // efla_drv

// file: testbench/efla_array_tb.sv
// Bench for the edge flop array: random and directed stimulus against a model
`timescale 1ns/10ps
module efla_array_tb;
    ////////////////////////////////////////////////////////////
    logic sys_clk, rst_n, run, pre_req, clr_req, preset_unknown, clear_unknown; // Stimulus
    logic elem_clk, preset_n, clear_n; // From the partner model
    logic [3:0] data_a, data_b; // Shared data lines
    logic [3:0] tq [5]; // True outputs
    logic [3:0] cq [5]; // Complement outputs
    logic [3:0] uq [5]; // Unknown flags
    logic tw [5]; // Warn pulses
    int fail_count = 0;
    int samples_checked = 0;
    bit [31:0] r = 32'h940d2518; // Random state
    bit [3:0] seq [8] = '{4'h1, 4'h4, 4'h1, 4'h2, 4'h8, 4'h2, 4'h4, 4'h0}; // pre, clr, pu, cu
    ////////////////////////////////////////////////////////////
    // JK select 0, D select 1, D select 2 with setup check, SR latch, single element D latch
    for (genvar g = 0; g < 5; g++) begin : gen_el
        efla_array #(.KIND(g == 0 ? efla_pkg::KIND_JK_EDGE_FLOP : g == 3 ? efla_pkg::KIND_SR_GATED_LATCH :
            g == 4 ? efla_pkg::KIND_DATA_GATED_LATCH : efla_pkg::KIND_DATA_EDGE_FLOP), .COUNT(4),
            .TEXT_FORM(g != 4), .POWER_ON_STATE_SELECT(g > 2 ? 0 : g),
            .SETUP_NS(g == 2 ? 80 : 0)) efla_array_i (
            .sys_clk(sys_clk), .rst_n(rst_n), .elem_clk(elem_clk), .preset_n(preset_n), .clear_n(clear_n),
            .preset_unknown(preset_unknown), .clear_unknown(clear_unknown), .data_a(data_a), .data_b(data_b),
            .true_output(tq[g]), .complement_output(cq[g]), .unknown_output(uq[g]), .timing_warn(tw[g]));
    end
    efla_drv efla_drv_i (.sys_clk(sys_clk), .run(run), .pre_req(pre_req), .clr_req(clr_req),
        .elem_clk(elem_clk), .preset_n(preset_n), .clear_n(clear_n));
    ////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input string nm, input logic [3:0] e, input logic [3:0] s);
        samples_checked++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Next value of the random sequence
    function automatic bit [31:0] lfsr(input bit [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Counts, verdict and end of run
    task automatic tally_and_finish;
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    // Behavioural model: state, unknown flags, pending commit
    bit [3:0] st [5], un [5], pend [5];
    bit pv [5];
    bit wexp, wchk, pclk, act;
    bit [7:0] pdat;
    int stab;
    always @(posedge sys_clk) begin
        for (int g = 0; g < 5; g++) begin
            if (rst_n) begin
                check("true_output", st[g] & ~un[g], tq[g] & ~un[g]);
                check("complement_output", ~st[g] & ~un[g], cq[g] & ~un[g]);
                check("unknown_output", un[g], uq[g]);
                if (g != 2 || wchk)
                    check("timing_warn", {3'h0, g == 2 && wexp}, {3'h0, tw[g]});
            end
            if (!rst_n) begin
                st[g] = g == 1 ? 4'hf : 4'h0;
                un[g] = g == 2 ? 4'hf : 4'h0;
                pv[g] = 1'b0;
            end else begin
                // Commit one cycle after the active event
                if (pv[g]) {st[g], un[g], pv[g]} = {pend[g], 4'h0, 1'b0};
                // Falling edge, rising edge, or gate level for the latches
                act = g == 0 ? pclk & ~elem_clk : g < 3 ? ~pclk & elem_clk : elem_clk;
                if (!clear_n) {st[g], un[g]} = 8'h00;
                else if (!preset_n) {st[g], un[g]} = 8'hf0;
                else begin
                    un[g] |= (clear_unknown ? st[g] : 4'h0) | (preset_unknown ? ~st[g] : 4'h0);
                    if (act) {pend[g], pv[g]} = {g == 0 ? (data_a & ~st[g]) | (~data_b & st[g]) : g == 3 ?
                        (data_a & ~data_b) | (~(data_a ^ data_b) & st[g]) : data_a, 1'b1};
                end
                // Single element build keeps the other elements cleared and known
                if (g == 4) {st[g], un[g]} = {st[g] & 4'h1, un[g] & 4'h1};
            end
        end
        // Setup tracking for the checked flop: data stable for less than the setup time
        stab = (!rst_n || {data_a, data_b} != pdat) ? 0 : (stab < 9 ? stab + 1 : 9);
        wchk = rst_n;
        wexp = !pclk && elem_clk && preset_n && clear_n && stab * efla_pkg::SYS_CLK_PERIOD_NS < 80;
        pdat = {data_a, data_b};
        pclk = elem_clk;
    end
    ////////////////////////////////////////////////////////////
    // Clock
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // Hang guard
    initial begin
        #200000;
        fail_count++;
        tally_and_finish();
    end
    // Apply async and unknown controls for two cycles
    task automatic ctl(input bit [3:0] v);
        @(posedge sys_clk);
        #1 {pre_req, clr_req, preset_unknown, clear_unknown} = v;
        @(posedge sys_clk);
    endtask
    // Main sequence: random clocking and data, then forcing with a steady clock
    initial begin
        {rst_n, run, pre_req, clr_req, preset_unknown, clear_unknown, data_a, data_b} = '0;
        repeat (16) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        for (int p = 0; p < 2; p++) begin
            repeat (300) begin
                @(posedge sys_clk);
                r = lfsr(r);
                #1 run = r[4] | r[5]; // Idle spells check that a steady clock holds
                if (r[1:0] == 2'h0) {data_a, data_b} = r[15:8];
            end
            @(posedge sys_clk);
            #1 run = 1'b0;
            repeat (4) @(posedge sys_clk);
            // Mixed unknown, clear, harmless then raising unknown, preset, harmless unknown, clear
            foreach (seq[i]) ctl(seq[i]);
            ctl(4'h0);
        end
        ctl(4'h0);
        tally_and_finish();
    end
endmodule // efla_array_tb
